// ===== hdl/drive_off_command_logic.sv
// drive_off_command_logic: forms switch-on, coast-stop and quick-stop commands
//
// Summary of operation
// R1: switch-on command follows its selected source, as control word bit 0.
// R2: drive switches on only on a rising edge of the switch-on source.
// R3: in speed mode 20, low switch-on ramps down, suppresses pulses, inhibits.
// R4: after switch-on source reselection, a fresh rising edge is needed.
// R5: with switch-on low, either jog input may still switch the drive on.
// R6: a low switch-on source acknowledges pending switch-on inhibit.
// R7: only the source that powered up may power down.
// R8: coast-stop release is AND of two sources, as control word bit 1.
// R9: either coast-stop source low suppresses pulses at once and inhibits.
// R10: coast-stop released only when both sources are high.
// R11: quick-stop release is AND of two sources, as control word bit 2.
// R12: either quick-stop source low brakes on quick ramp, then inhibits.
// R13: quick-stop released only when both sources are high.
// R14: torque mode: low first quick-stop source waits for standstill, no braking.
// R15: PC master control ignores switch-on, coast one and quick one sources.
// R16: PC master control still honours the second coast-stop source.
// R17: status shows command set selection bits 0 and 1 from binary inputs.
// R18: status bit 0 shows drive set selected by binary input.
// R19: with only one drive set, drive set status reads zero.
// R20: switch-on, coast, quick-stop and jog source selectors are held per command data set.
// R21: sources evaluated every cycle; coast-stop outranks quick-stop and ramp-stop.
// R22: master-control status reads 0 for interconnection, 1 for PC.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module drive_off_command_logic (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire drive_off_pkg::reg_req_t req,
  output logic [31:0] rdata,
  // binary sources from pins, PC master control and drive feedback
  input wire logic [drive_off_pkg::NUM_SRC-1:0] pin_sources,
  input wire logic pc_master,
  input wire drive_off_pkg::ctrl_word_t pc_word,
  input wire drive_off_pkg::drive_fb_t fb,
  // command outputs
  output drive_off_pkg::ctrl_word_t ctrl_word,
  output logic pulse_enable,
  output logic ramp_brake,
  output logic quick_brake,
  output logic master_active
);
  import drive_off_pkg::*;

  // per-set selectors
  logic [31:0] switch_src_q [NUM_SETS];
  logic [31:0] coast1_src_q [NUM_SETS];
  logic [31:0] coast2_src_q [NUM_SETS];
  logic [31:0] quick1_src_q [NUM_SETS];
  logic [31:0] quick2_src_q [NUM_SETS];
  logic [31:0] jog_src_q [NUM_SETS];
  logic [31:0] config_q;
  logic [31:0] set_sel_src_q;
  logic [NUM_SRC-1:0] sync_src;
  logic [NUM_SRC-1:0] src;
  logic [1:0] cmd_set_sel;
  logic act_set;
  logic drive_set_sel;
  logic sw_raw, c1_raw, c2_raw, q1_raw, q2_raw, j1_raw, j2_raw, cs0_raw, cs1_raw, ds_raw;
  logic switch_on, coast_ok, quick_ok, quick1_low;
  logic switch_prev_q, jog1_prev_q, jog2_prev_q;
  logic rearm_q;
  logic master_q;
  drive_state_t state_q, state_d;
  owner_t owner_q, owner_d;
  logic torque_mode, speed_mode, one_set;
  logic main_rise, jog1_rise, jog2_rise, off_cmd;

  // pins pass the settling synchroniser; two constant lines lead the vector
  source_sync #(.W(NUM_SRC)) u_sync (
    .clk(clk),
    .rst(rst),
    .raw(pin_sources),
    .level(sync_src)
  );
  assign src = {sync_src[NUM_SRC-1:2], 1'b1, 1'b0};

  // set selection comes from binary inputs: low byte bit0, high byte bit1
  source_pick u_cs0 (.sources(src), .sel(set_sel_src_q[SRC_W-1:0]), .bit_out(cs0_raw));
  source_pick u_cs1 (.sources(src), .sel(set_sel_src_q[SEL_HI_LSB +: SRC_W]), .bit_out(cs1_raw));
  assign cmd_set_sel = {cs1_raw, cs0_raw};
  // only two sets are held, so bit 0 picks the active one
  assign act_set = cmd_set_sel[0]; // R20

  // drive set select source sits in the upper config field
  source_pick u_ds (.sources(src), .sel(config_q[CFG_DS_SEL_LSB +: SRC_W]), .bit_out(ds_raw));
  // the single-set flag forces the status to zero whatever the pin shows
  assign one_set = config_q[CFG_ONE_DRIVE_SET_BIT];
  assign drive_set_sel = one_set ? 1'b0 : ds_raw; // R19

  // selector lookups on the active command set
  source_pick u_sw (.sources(src), .sel(switch_src_q[act_set][SRC_W-1:0]), .bit_out(sw_raw));
  source_pick u_c1 (.sources(src), .sel(coast1_src_q[act_set][SRC_W-1:0]), .bit_out(c1_raw));
  source_pick u_c2 (.sources(src), .sel(coast2_src_q[act_set][SRC_W-1:0]), .bit_out(c2_raw));
  source_pick u_q1 (.sources(src), .sel(quick1_src_q[act_set][SRC_W-1:0]), .bit_out(q1_raw));
  source_pick u_q2 (.sources(src), .sel(quick2_src_q[act_set][SRC_W-1:0]), .bit_out(q2_raw));
  source_pick u_j1 (.sources(src), .sel(jog_src_q[act_set][SRC_W-1:0]), .bit_out(j1_raw));
  source_pick u_j2 (
    .sources(src),
    .sel(jog_src_q[act_set][SEL_HI_LSB +: SRC_W]),
    .bit_out(j2_raw)
  );

  // pc master control replaces the first sources with its own word
  always_comb begin
    switch_on = master_q ? pc_word.switch_on : sw_raw; // R1 R15
    coast_ok = (master_q ? pc_word.coast_release : c1_raw) & c2_raw; // R8 R10 R16
    quick_ok = (master_q ? pc_word.quick_release : q1_raw) & q2_raw; // R11 R13 R15
    quick1_low = ~(master_q ? pc_word.quick_release : q1_raw);
  end

  assign torque_mode = config_q[CFG_TORQUE_BIT];
  assign speed_mode = config_q[CFG_MODE_LSB +: CFG_MODE_W] == MODE_SPEED_CLOSED;
  assign main_rise = switch_on & ~switch_prev_q & ~rearm_q; // R2 R4
  assign jog1_rise = j1_raw & ~jog1_prev_q & ~switch_on; // R5
  assign jog2_rise = j2_raw & ~jog2_prev_q & ~switch_on; // R5

  // power-down only from the owning source
  always_comb begin
    unique case (owner_q)
      OWNER_MAIN: off_cmd = ~switch_on; // R7
      OWNER_JOG1: off_cmd = ~j1_raw; // R7
      OWNER_JOG2: off_cmd = ~j2_raw; // R7
      default: off_cmd = 1'b0;
    endcase
  end

  // edge history, refreshed every cycle; reset high so no false rise follows reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      switch_prev_q <= 1'b1;
      jog1_prev_q <= 1'b1;
      jog2_prev_q <= 1'b1;
    end else begin
      switch_prev_q <= switch_on;
      jog1_prev_q <= j1_raw;
      jog2_prev_q <= j2_raw;
    end
  end

  // master control flag; the pc side runs on this clock, so one flop suffices
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      master_q <= 1'b0;
    end else begin
      master_q <= pc_master; // R22
    end
  end

  // sequencing; coast-stop checked first so it outranks the others
  always_comb begin
    state_d = state_q;
    owner_d = owner_q;
    if (!coast_ok && state_q != ST_INHIBIT) begin
      state_d = ST_INHIBIT; // R9 R21
      owner_d = OWNER_NONE;
    end else begin
      unique case (state_q)
        ST_INHIBIT: begin
          // a low switch-on level clears the inhibit
          if (!switch_on && coast_ok && quick_ok) begin
            state_d = ST_READY; // R6
          end
        end
        ST_READY: begin
          if (!quick_ok) begin
            state_d = ST_INHIBIT;
          end else if (main_rise) begin
            state_d = ST_RUN; // R2
            owner_d = OWNER_MAIN;
          end else if (jog1_rise) begin
            state_d = ST_RUN;
            owner_d = OWNER_JOG1;
          end else if (jog2_rise) begin
            state_d = ST_RUN;
            owner_d = OWNER_JOG2;
          end
        end
        ST_RUN: begin
          if (!quick_ok) begin
            state_d = ST_QUICK; // R12 R21
          end else if (off_cmd && speed_mode) begin
            state_d = ST_RAMP; // R3
          end else if (off_cmd) begin
            // other modes have no ramp of their own here and drop straight out
            state_d = ST_INHIBIT;
            owner_d = OWNER_NONE;
          end
        end
        ST_RAMP: begin
          if (!quick_ok) begin
            state_d = ST_QUICK; // R21
          end else if (fb.ramp_done) begin
            state_d = ST_INHIBIT; // R3
            owner_d = OWNER_NONE;
          end
        end
        ST_QUICK: begin
          // torque mode with the first source low waits for standstill, every other case for the quick ramp
          if (torque_mode && quick1_low ? fb.standstill : fb.ramp_done) begin
            state_d = ST_INHIBIT; // R12 R14
            owner_d = OWNER_NONE;
          end
        end
      endcase
    end
  end

  // sequencing state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_INHIBIT;
    end else begin
      state_q <= state_d;
    end
  end

  // owning source, kept apart so a power-down can be traced to its source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      owner_q <= OWNER_NONE;
    end else begin
      owner_q <= owner_d; // R7
    end
  end

  // reselecting the switch-on source blocks switch-on until it goes low again
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rearm_q <= 1'b0;
    end else if (req.wr && req.addr == ADDR_SWITCH_ON_SRC) begin
      rearm_q <= 1'b1; // R4
    end else if (!switch_on) begin
      rearm_q <= 1'b0;
    end
  end

  // per-set selector registers; writes go to the active set
  genvar g;
  generate
    for (g = 0; g < NUM_SETS; g++) begin : g_set
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          switch_src_q[g] <= RST_SWITCH_ON_SRC;
          coast1_src_q[g] <= RST_COAST_SRC;
          coast2_src_q[g] <= RST_COAST_SRC;
          quick1_src_q[g] <= RST_QUICK_SRC;
          quick2_src_q[g] <= RST_QUICK_SRC;
          jog_src_q[g] <= RST_JOG_SRC;
        end else if (req.wr && act_set == 1'(g)) begin
          unique case (req.addr)
            ADDR_SWITCH_ON_SRC: switch_src_q[g] <= req.wdata; // R20
            ADDR_COAST_SRC_ONE: coast1_src_q[g] <= req.wdata;
            ADDR_COAST_SRC_TWO: coast2_src_q[g] <= req.wdata;
            ADDR_QUICK_SRC_ONE: quick1_src_q[g] <= req.wdata;
            ADDR_QUICK_SRC_TWO: quick2_src_q[g] <= req.wdata;
            ADDR_JOG_SRC: jog_src_q[g] <= req.wdata;
            default: ;
          endcase
        end
      end
    end
  endgenerate

  // shared configuration register, common to both command sets
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_q <= RST_CONFIG;
    end else if (req.wr && req.addr == ADDR_CONFIG) begin
      config_q <= req.wdata;
    end
  end

  // set selection sources; a change here moves every per-set selector lookup at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      set_sel_src_q <= RST_SET_SELECT_SRC;
    end else if (req.wr && req.addr == ADDR_SET_SELECT_SRC) begin
      set_sel_src_q <= req.wdata; // R17
    end
  end

  // read data in the cycle after the strobe, zero otherwise and when unmapped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (req.rd) begin
      unique case (req.addr)
        ADDR_SWITCH_ON_SRC: rdata <= switch_src_q[act_set];
        ADDR_COAST_SRC_ONE: rdata <= coast1_src_q[act_set];
        ADDR_COAST_SRC_TWO: rdata <= coast2_src_q[act_set];
        ADDR_QUICK_SRC_ONE: rdata <= quick1_src_q[act_set];
        ADDR_QUICK_SRC_TWO: rdata <= quick2_src_q[act_set];
        ADDR_JOG_SRC: rdata <= jog_src_q[act_set];
        ADDR_CONFIG: rdata <= config_q;
        ADDR_SET_SELECT_SRC: rdata <= set_sel_src_q;
        ADDR_CMD_SET_STATUS: rdata <= {30'h0, cmd_set_sel}; // R17
        ADDR_DRIVE_SET_STATUS: rdata <= {31'h0, drive_set_sel}; // R18 R19
        ADDR_MASTER_STATUS: rdata <= {31'h0, master_q}; // R22
        ADDR_DRIVE_STATE: begin
          rdata <= {17'h0, owner_q, pulse_enable, 1'b0, ctrl_word, 3'h0, state_q};
        end
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // effective control word, one cycle behind the sources
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_word <= '0;
    end else begin
      ctrl_word <= '{quick_release: quick_ok, coast_release: coast_ok, switch_on: switch_on};
    end
  end

  // pulse and brake outputs follow the next state so they change together with it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_enable <= 1'b0;
      ramp_brake <= 1'b0;
      quick_brake <= 1'b0;
    end else begin
      pulse_enable <= state_d inside {ST_RUN, ST_RAMP, ST_QUICK}; // R9
      ramp_brake <= state_d == ST_RAMP; // R3
      // torque mode with low first source brakes nothing of its own
      quick_brake <= state_d == ST_QUICK && !(torque_mode && quick1_low); // R14
    end
  end

  // master status output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      master_active <= 1'b0;
    end else begin
      master_active <= master_q; // R22
    end
  end
endmodule

// ===== hdl/drive_off_pkg.sv
// package: register map, field layout and types of the drive off-command logic
package drive_off_pkg;

  // register indices on the plain register port (word addresses)
  localparam logic [7:0] ADDR_SWITCH_ON_SRC = 8'h00;
  localparam logic [7:0] ADDR_COAST_SRC_ONE = 8'h01;
  localparam logic [7:0] ADDR_COAST_SRC_TWO = 8'h02;
  localparam logic [7:0] ADDR_QUICK_SRC_ONE = 8'h03;
  localparam logic [7:0] ADDR_QUICK_SRC_TWO = 8'h04;
  localparam logic [7:0] ADDR_JOG_SRC = 8'h05;
  localparam logic [7:0] ADDR_CONFIG = 8'h06;
  localparam logic [7:0] ADDR_SET_SELECT_SRC = 8'h07;
  localparam logic [7:0] ADDR_CMD_SET_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DRIVE_SET_STATUS = 8'h09;
  localparam logic [7:0] ADDR_MASTER_STATUS = 8'h0a;
  localparam logic [7:0] ADDR_DRIVE_STATE = 8'h0b;

  // number of command data sets and binary source lines
  localparam int NUM_SETS = 2;
  localparam int SRC_W = 5;
  localparam int NUM_SRC = 32;

  // source selector reset values (index into binary source vector)
  localparam logic [31:0] RST_SWITCH_ON_SRC = 32'h0000_0000;
  localparam logic [31:0] RST_COAST_SRC = 32'h0000_0001;
  localparam logic [31:0] RST_QUICK_SRC = 32'h0000_0001;
  localparam logic [31:0] RST_JOG_SRC = 32'h0000_0000;
  localparam logic [31:0] RST_SET_SELECT_SRC = 32'h0000_0000;
  localparam logic [31:0] RST_CONFIG = 32'h0000_0000;

  // binary source 0 is constant low, source 1 constant high
  localparam logic [4:0] SRC_CONST_LOW = 5'h00;
  localparam logic [4:0] SRC_CONST_HIGH = 5'h01;

  // config register fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_MODE_W = 8;
  localparam int CFG_TORQUE_BIT = 8;
  localparam int CFG_ONE_DRIVE_SET_BIT = 9;
  localparam int CFG_DS_SEL_LSB = 16;
  localparam logic [7:0] MODE_SPEED_CLOSED = 8'd20;

  // source selection fields: jog register holds two selectors, set-select holds two
  localparam int SEL_HI_LSB = 8;

  // drive state register layout
  localparam int ST_STATE_LSB = 0;
  localparam int ST_CW_LSB = 8;
  localparam int ST_PULSE_BIT = 12;
  localparam int ST_OWNER_LSB = 13;

  // drive sequencing states, one-hot
  typedef enum logic [4:0] {
    ST_INHIBIT = 5'b00001,
    ST_READY = 5'b00010,
    ST_RUN = 5'b00100,
    ST_RAMP = 5'b01000,
    ST_QUICK = 5'b10000
  } drive_state_t;

  // which source powered the drive up
  typedef enum logic [1:0] {
    OWNER_NONE = 2'd0,
    OWNER_MAIN = 2'd1,
    OWNER_JOG1 = 2'd2,
    OWNER_JOG2 = 2'd3
  } owner_t;

  // low bits of control word 1
  typedef struct packed {
    logic quick_release;
    logic coast_release;
    logic switch_on;
  } ctrl_word_t;

  // drive-side feedback
  typedef struct packed {
    logic ramp_done;
    logic standstill;
  } drive_fb_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// ===== hdl/source_sync.sv
// source_sync: three-stage synchroniser with agreement check for pin inputs
`timescale 1ns/1ps
module source_sync #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw and settled levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // stage one is read only by stage two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a level change counts only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          level[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          level[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule

// ===== hdl/source_pick.sv
// source_pick: selects one binary source from the source vector
`timescale 1ns/1ps
module source_pick (
  // source vector and selector
  input wire logic [drive_off_pkg::NUM_SRC-1:0] sources,
  input wire logic [drive_off_pkg::SRC_W-1:0] sel,
  // chosen level
  output logic bit_out
);
  import drive_off_pkg::*;
  assign bit_out = sources[sel];
endmodule

// ===== test/ctl_model.sv
// ctl_model: controller at the far side driving pin levels and the pc word
`timescale 1ns/1ps
module ctl_model (
  // clock
  input wire logic clk,
  // wanted levels from the bench
  input wire logic [31:0] pins_cmd,
  input wire logic master_cmd,
  input wire drive_off_pkg::ctrl_word_t word_cmd,
  input wire logic slow,
  // levels towards the block
  output logic [31:0] pin_sources = 32'h0,
  output logic pc_master = 1'b0,
  output drive_off_pkg::ctrl_word_t pc_word = 3'h0
);
  logic [31:0] pins_q = 32'h0;
  // a slow controller lags its pin levels one more cycle, like a busy fieldbus
  always @(posedge clk) begin
    pins_q <= pins_cmd;
    pin_sources <= slow ? pins_q : pins_cmd;
    pc_master <= master_cmd;
    pc_word <= word_cmd;
  end
endmodule

// ===== test/off_cmd_chk.sv
// off_cmd_chk: port checks of the drive off-command logic
`timescale 1ns/1ps
module off_cmd_chk
  import drive_off_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire drive_off_pkg::reg_req_t req,
  input wire logic [31:0] rdata,
  // command outputs
  input wire drive_off_pkg::ctrl_word_t ctrl_word,
  input wire logic pulse_enable,
  input wire logic ramp_brake,
  input wire logic quick_brake,
  input wire logic master_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // read strobes of interest
  sequence s_rd_master;
    req.rd && req.addr == ADDR_MASTER_STATUS;
  endsequence
  sequence s_rd_hole;
    req.rd && req.addr > ADDR_DRIVE_STATE;
  endsequence
  // coast stop seen on the effective word
  sequence s_coast;
    !ctrl_word.coast_release;
  endsequence
  property p_idle_rdata;
    !$past(req.rd) |-> rdata == 32'h0;
  endproperty
  property p_hole;
    s_rd_hole |=> rdata == 32'h0;
  endproperty
  // read data and the output both come from the same registered flag
  property p_master;
    s_rd_master |=> rdata == {31'h0, master_active};
  endproperty
  property p_coast_pulse;
    s_coast |-> ##[0:1] !pulse_enable;
  endproperty
  property p_coast_first;
    s_coast |-> ##[0:1] !(ramp_brake || quick_brake);
  endproperty
  property p_ramp_pulse;
    ramp_brake |-> pulse_enable;
  endproperty
  property p_quick_pulse;
    quick_brake |-> pulse_enable;
  endproperty
  property p_on_released;
    $rose(pulse_enable) |-> ctrl_word.coast_release && ctrl_word.quick_release;
  endproperty
  property p_one_brake;
    !(ramp_brake && quick_brake);
  endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside a read");
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  a_master: assert property (p_master) else $error("master status wrong");
  a_coast_pulse: assert property (p_coast_pulse) else $error("pulses kept on coast");
  a_coast_first: assert property (p_coast_first) else $error("brake during coast");
  a_ramp_pulse: assert property (p_ramp_pulse) else $error("ramp without pulses");
  a_quick_pulse: assert property (p_quick_pulse) else $error("quick without pulses");
  a_on_released: assert property (p_on_released) else $error("enabled while stopped");
  a_one_brake: assert property (p_one_brake) else $error("two brakes at once");
endmodule

bind drive_off_command_logic off_cmd_chk chk_u (.clk(clk), .rst(rst), .req(req),
  .rdata(rdata), .ctrl_word(ctrl_word), .pulse_enable(pulse_enable),
  .ramp_brake(ramp_brake), .quick_brake(quick_brake), .master_active(master_active));

// ===== test/tb_top.sv
// tb_top: self-checking bench of the drive off-command logic
`timescale 1ns/1ps
module tb_top;
  import drive_off_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  reg_req_t req = '0;
  logic [31:0] rdata;
  logic [31:0] pins_cmd = 32'h0;
  logic master_cmd = 1'b0;
  ctrl_word_t word_cmd = 3'h0;
  logic slow = 1'b0;
  drive_fb_t fb = 2'h0;
  logic [31:0] pin_sources;
  logic pc_master;
  ctrl_word_t pc_word;
  ctrl_word_t ctrl_word;
  logic pulse_enable;
  logic ramp_brake;
  logic quick_brake;
  logic master_active;
  logic [2:0] obs;
  logic [11:0] lo = 12'h078;
  logic [31:0] rnd = 32'hd9ce;
  int n_errors = 0;
  int total_checks = 0;
  int n;
  assign obs = {quick_brake, ramp_brake, pulse_enable};
  // 125 MHz clock
  always #4 clk = ~clk;
  ctl_model ctl_u (.clk(clk), .pins_cmd(pins_cmd), .master_cmd(master_cmd),
    .word_cmd(word_cmd), .slow(slow), .pin_sources(pin_sources), .pc_master(pc_master),
    .pc_word(pc_word));
  drive_off_command_logic dut_u (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .pin_sources(pin_sources), .pc_master(pc_master), .pc_word(pc_word), .fb(fb),
    .ctrl_word(ctrl_word), .pulse_enable(pulse_enable), .ramp_brake(ramp_brake),
    .quick_brake(quick_brake), .master_active(master_active));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // reset value of each word; unmapped words read zero
  function automatic logic [31:0] rst_val(input int a);
    case (a)
      1, 2: return RST_COAST_SRC;
      3, 4: return RST_QUICK_SRC;
      11: return {17'h0, OWNER_NONE, 2'b00, 3'b110, 3'h0, ST_READY};
      default: return 32'h0;
    endcase
  endfunction
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // upper pins carry random noise so the selectors really pick
  task automatic pin(input int i, input logic v);
    @(posedge clk);
    lo[i] = v;
    rnd = xs(rnd);
    pins_cmd <= {rnd[31:12], lo};
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wt(input int k, input logic v);
    n = 0;
    do begin
      idle(1);
      n++;
      if (n > 300) begin
        chk(32'h0, 32'h1);
        wrap_up;
      end
    end while (obs[k] !== v);
  endtask
  task automatic fbk(input drive_fb_t v);
    @(posedge clk);
    fb <= v;
  endtask
  task automatic sw_on;
    pin(2, 0);
    idle(8);
    pin(2, 1);
    wt(0, 1'b1);
    chk(32'(ctrl_word), 32'h7);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) rd(8'(a), rst_val(a));
    for (int i = 0; i < 5; i++) wr(8'(i), 32'(i + 2));
    wr(ADDR_CONFIG, 32'h0007_0014);
    for (int i = 0; i < 5; i++) rd(8'(i), 32'(i + 2));
    sw_on;
    rd(ADDR_DRIVE_STATE, {17'h0, OWNER_MAIN, 2'b10, 3'b111, 3'h0, ST_RUN});
    // ramp stop keeps pulses until the ramp is done
    pin(2, 0);
    wt(1, 1'b1);
    chk(32'(pulse_enable), 32'h1);
    fbk(2'b11);
    wt(0, 1'b0);
    fbk(2'b00);
    // each stop source in turn; no restart without a fresh edge
    for (int k = 3; k < 7; k++) begin
      sw_on;
      pin(k, 0);
      if (k > 4) begin
        wt(2, 1'b1);
        chk(32'(ramp_brake), 32'h0);
        fbk(2'b11);
      end
      wt(0, 1'b0);
      if (k < 5) chk(32'(n < 9), 32'h1);
      chk(32'(ctrl_word), k < 5 ? 32'h5 : 32'h3);
      fbk(2'b00);
      pin(k, 1);
      idle(10);
      chk(32'(pulse_enable), 32'h0);
    end
    // a reselected source that is already high must not switch on
    pin(2, 0);
    idle(8);
    wr(ADDR_SWITCH_ON_SRC, 32'h1);
    idle(10);
    chk(32'(pulse_enable), 32'h0);
    wr(ADDR_SWITCH_ON_SRC, 32'h2);
    // jog while main is low; main cannot stop it
    wr(ADDR_JOG_SRC, 32'h0000_0b0a);
    for (int j = 10; j < 12; j++) begin
      pin(j, 1);
      wt(0, 1'b1);
      // held long enough to pass the pin filter
      pin(2, 1);
      idle(8);
      pin(2, 0);
      idle(10);
      chk(32'(pulse_enable), 32'h1);
      fbk(2'b11);
      pin(j, 0);
      wt(0, 1'b0);
      fbk(2'b00);
    end
    wr(ADDR_JOG_SRC, 32'h0);
    // torque mode waits for standstill instead of braking
    wr(ADDR_CONFIG, 32'h0007_0100);
    sw_on;
    pin(5, 0);
    idle(12);
    chk(32'(obs), 32'h1);
    fbk(2'b01);
    wt(0, 1'b0);
    fbk(2'b00);
    pin(5, 1);
    // outside speed mode a switch-off drops pulses at once, with no ramp
    sw_on;
    pin(2, 0);
    wt(0, 1'b0);
    chk(32'(ramp_brake), 32'h0);
    wr(ADDR_CONFIG, 32'h0007_0014);
    // pc master through a slow controller
    slow <= 1'b1;
    master_cmd <= 1'b1;
    word_cmd <= 3'b110;
    idle(8);
    word_cmd <= 3'b111;
    wt(0, 1'b1);
    rd(ADDR_MASTER_STATUS, 32'h1);
    chk(32'(master_active), 32'h1);
    pin(2, 0);
    pin(3, 0);
    pin(5, 0);
    idle(10);
    chk(32'(pulse_enable), 32'h1);
    pin(4, 0);
    wt(0, 1'b0);
    master_cmd <= 1'b0;
    slow <= 1'b0;
    pin(3, 1);
    pin(4, 1);
    pin(5, 1);
    // selection status from the pins
    pin(7, 1);
    idle(8);
    chk(32'(master_active), 32'h0);
    rd(ADDR_DRIVE_SET_STATUS, 32'h1);
    wr(ADDR_CONFIG, 32'h0007_0214);
    rd(ADDR_DRIVE_SET_STATUS, 32'h0);
    wr(ADDR_SET_SELECT_SRC, 32'h0000_0908);
    pin(9, 1);
    pin(8, 1);
    idle(8);
    rd(ADDR_CMD_SET_STATUS, 32'h3);
    rd(ADDR_SWITCH_ON_SRC, RST_SWITCH_ON_SRC);
    wr(ADDR_SWITCH_ON_SRC, 32'h7);
    pin(8, 0);
    idle(8);
    rd(ADDR_SWITCH_ON_SRC, 32'h2);
    rd(ADDR_CMD_SET_STATUS, 32'h2);
    wrap_up;
  end
endmodule
